// ==== rtl/pef_pin_cell.sv ====
package pef_pkg;

   // Register map and field layout of the function control word.
   localparam logic [31:0] CTL_OFFSET     = 32'h0000_0000;
   localparam int          CTL_WIDTH      = 16;
   localparam logic [15:0] CTL_RESET      = 16'h0000;
   localparam int          PIN14_MODE_LSB = 12;
   localparam int          PIN13_MODE_LSB = 10;
   localparam int          PIN12_MODE_LSB = 8;
   localparam logic [15:0] CTL_RW_MASK    = 16'h3F00;

   // AHB-Lite encodings used by the slave.
   localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;
   localparam logic        HRESP_OKAY     = 1'h0;

   // What the third function of a pin does.
   localparam logic [1:0]  ALT_OUTPUT     = 2'h0;
   localparam logic [1:0]  ALT_INPUT      = 2'h1;
   localparam logic [1:0]  ALT_NONE       = 2'h2;

   typedef enum logic [1:0] {
      PEF_MD_PORT  = 2'b00,
      PEF_MD_TIMER = 2'b01,
      PEF_MD_ALT   = 2'b10,
      PEF_MD_RSVD  = 2'b11
   } pef_mode_t;

endpackage : pef_pkg

module pef_pin_cell #(
   parameter logic [1:0] ALT_KIND      = pef_pkg::ALT_OUTPUT,
   parameter bit         TIMER_ON_RSVD = 1'b0
) (
   // Clock and reset.
   input  wire logic       sys_clk,
   input  wire logic       rst,
   // Selection.
   input  wire logic [1:0] mode,
   input  wire logic       force_in,
   // Pad.
   input  wire logic       pin_i,
   output logic            pin_o,
   output logic            pin_oe,
   // Port function.
   input  wire logic       port_do,
   input  wire logic       port_oe,
   output logic            port_di,
   // Timer function.
   input  wire logic       tmr_do,
   input  wire logic       tmr_oe,
   output logic            tmr_di,
   // Third function and forced input.
   input  wire logic       alt_do,
   output logic            alt_di,
   output logic            force_di
);

   typedef struct packed {
      logic s1;
      logic s2;
      logic o;
      logic oe;
   } pef_cell_t;

   pef_cell_t cell_r;
   pef_cell_t cell_nxt;
   logic      sel_tmr;
   logic      sel_alt;

   always_comb begin
      sel_tmr = !force_in && (mode == pef_pkg::PEF_MD_TIMER ||
                (TIMER_ON_RSVD && mode == pef_pkg::PEF_MD_RSVD));
      sel_alt = !force_in && mode == pef_pkg::PEF_MD_ALT && ALT_KIND != pef_pkg::ALT_NONE;
      cell_nxt    = cell_r;
      cell_nxt.s1 = pin_i;
      cell_nxt.s2 = cell_r.s1;
      cell_nxt.o  = 1'b0;
      cell_nxt.oe = 1'b0;
      if (force_in) begin
         cell_nxt.oe = 1'b0;
      end else if (mode == pef_pkg::PEF_MD_PORT) begin
         cell_nxt.o  = port_do;
         cell_nxt.oe = port_oe;
      end else if (sel_tmr) begin
         cell_nxt.o  = tmr_do;
         cell_nxt.oe = tmr_oe;
      end else if (sel_alt && ALT_KIND == pef_pkg::ALT_OUTPUT) begin
         cell_nxt.o  = alt_do;
         cell_nxt.oe = 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         cell_r <= '0;
      end else begin
         cell_r <= cell_nxt;
      end
   end

   assign pin_o    = cell_r.o;
   assign pin_oe   = cell_r.oe;
   assign port_di  = cell_r.s2;
   assign tmr_di   = sel_tmr ? cell_r.s2 : 1'b0;
   assign alt_di   = (sel_alt && ALT_KIND == pef_pkg::ALT_INPUT) ? cell_r.s2 : 1'b0;
   assign force_di = force_in ? cell_r.s2 : 1'b0;

endmodule : pef_pin_cell

// ==== rtl/pef_pin_select.sv ====
// Overview of operation
// - Pin 14 mode: port, timer C, DMA acknowledge.
// - Pin 13 mode: port, timer B, manual reset.
// - Pin 12 mode: port or timer A.
// - Debug mode forces pin 12 to test clock.
//
// Implementation choices: the AHB-Lite register port and the address map.
module pef_pin_select #(
   parameter int HADDR_W = 32
) (
   // Clock and reset.
   input  wire logic               sys_clk,
   input  wire logic               rst,
   // AHB-Lite slave.
   input  wire logic               hsel,
   input  wire logic [HADDR_W-1:0] haddr,
   input  wire logic [1:0]         htrans,
   input  wire logic               hwrite,
   input  wire logic [2:0]         hsize,
   input  wire logic [31:0]        hwdata,
   input  wire logic               hready,
   output logic                    hreadyout,
   output logic                    hresp,
   output logic [31:0]             hrdata,
   // Debug emulator mode strap pin.
   input  wire logic               debug_emulator_mode_pin,
   // Pads of port E bits 14, 13 and 12.
   input  wire logic               port_bit_fourteen_i,
   output logic                    port_bit_fourteen_o,
   output logic                    port_bit_fourteen_oe,
   input  wire logic               port_bit_thirteen_i,
   output logic                    port_bit_thirteen_o,
   output logic                    port_bit_thirteen_oe,
   input  wire logic               port_bit_twelve_i,
   output logic                    port_bit_twelve_o,
   output logic                    port_bit_twelve_oe,
   // General port I/O, index 2 is bit 14, index 0 is bit 12.
   input  wire logic [2:0]         port_do,
   input  wire logic [2:0]         port_oe,
   output logic [2:0]              port_di,
   // Multi-function timer channel 4, index 2 is C, 1 is B, 0 is A.
   input  wire logic [2:0]         timer_ch4_do,
   input  wire logic [2:0]         timer_ch4_oe,
   output logic [2:0]              timer_ch4_di,
   // DMA unit, interrupt unit and debug unit.
   input  wire logic               dma_acknowledge_zero,
   output logic                    manual_reset_input,
   output logic                    test_clock_input,
   // Current pin modes.
   output logic [1:0]              pin14_mode,
   output logic [1:0]              pin13_mode,
   output logic [1:0]              pin12_mode
);

   if (HADDR_W < 4 || HADDR_W > 32) begin : g_chk
      $error("pef_pin_select: HADDR_W must lie between 4 and 32");
   end

   // The mode bits are stored as one six-bit slice, the bit 12 field lowest.
   if (pef_pkg::PIN13_MODE_LSB != pef_pkg::PIN12_MODE_LSB + 2 ||
       pef_pkg::PIN14_MODE_LSB != pef_pkg::PIN12_MODE_LSB + 4) begin : g_chk_fields
      $error("pef_pin_select: mode fields must be adjacent");
   end

   if (pef_pkg::PIN14_MODE_LSB + 2 > pef_pkg::CTL_WIDTH) begin : g_chk_width
      $error("pef_pin_select: mode fields must fit the control word");
   end

   // Whole slave state: debug strap synchroniser, the six mode bits, the address
   // of a write waiting for its data phase and the registered read data.
   typedef struct packed {
      logic                dbg_s1;
      logic                dbg_s2;
      logic [5:0]          modes;
      logic                wr_pend;
      logic [HADDR_W-1:0]  wr_addr;
      logic [31:0]         rdata;
   } pef_state_t;

   pef_state_t st_r;
   pef_state_t st_nxt;
   logic       take;
   logic       wr_now;
   logic [5:0] wr_modes;
   logic [15:0] ctl_view;

   // Only word addresses are decoded; the byte lane bits are ignored.
   function automatic logic hit_ctl(input logic [HADDR_W-1:0] a);
      hit_ctl = a[HADDR_W-1:2] == pef_pkg::CTL_OFFSET[HADDR_W-1:2];
   endfunction : hit_ctl

   // Unused and reserved bits of the control word read as zero.
   function automatic logic [15:0] ctl_word(input logic [5:0] m);
      ctl_word = {2'h0, m, 8'h00} & pef_pkg::CTL_RW_MASK;
   endfunction : ctl_word

   function automatic logic [1:0] field(input logic [15:0] w, input int lsb);
      field = w[lsb +: 2];
   endfunction : field

   // A write lands at the end of its data phase, when hwdata stands. The read data
   // is built from the mode bits as they will be after this edge, so a read that
   // directly follows a write returns the new value.
   always_comb begin
      take     = hsel && hready && htrans == pef_pkg::HTRANS_NONSEQ;
      wr_now   = st_r.wr_pend && hit_ctl(st_r.wr_addr);
      wr_modes = st_r.modes;
      if (wr_now) begin
         wr_modes = hwdata[pef_pkg::PIN12_MODE_LSB +: 6];
      end
      ctl_view = ctl_word(wr_modes);

      st_nxt        = st_r;
      st_nxt.dbg_s1 = debug_emulator_mode_pin;
      st_nxt.dbg_s2 = st_r.dbg_s1;
      st_nxt.modes  = wr_modes;
      st_nxt.wr_pend = 1'b0;
      if (take) begin
         st_nxt.wr_pend = hwrite;
         st_nxt.wr_addr = haddr;
         st_nxt.rdata   = 32'h0000_0000;
         if (!hwrite && hit_ctl(haddr)) begin
            // A write finishing in this cycle is forwarded to a read behind it.
            st_nxt.rdata = {16'h0000, ctl_view};
         end
      end
   end

   // Reset clears the synchroniser and the pending write; every pin starts as port I/O.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         st_r       <= '0;
         st_r.modes <= pef_pkg::CTL_RESET[pef_pkg::PIN12_MODE_LSB +: 6];
      end else begin
         st_r <= st_nxt;
      end
   end

   // Zero wait states and no error response: every transfer ends in its data phase.
   assign hreadyout = 1'b1;
   assign hresp     = pef_pkg::HRESP_OKAY;
   assign hrdata    = st_r.rdata;

   // The mode outputs follow the stored control word, so they change one cycle
   // after the data phase of a write, and the pads one cycle later still.
   assign pin14_mode = field(ctl_word(st_r.modes), pef_pkg::PIN14_MODE_LSB);
   assign pin13_mode = field(ctl_word(st_r.modes), pef_pkg::PIN13_MODE_LSB);
   assign pin12_mode = field(ctl_word(st_r.modes), pef_pkg::PIN12_MODE_LSB);

   // Bit 14: port, timer C, DMA acknowledge output; code 11 leaves the pad released.
   // In DMA mode the pad is always driven and carries the acknowledge level.
   pef_pin_cell #(
      .ALT_KIND      (pef_pkg::ALT_OUTPUT),
      .TIMER_ON_RSVD (1'b0)
   ) u_pin14 (
      .sys_clk  (sys_clk),
      .rst      (rst),
      .mode     (pin14_mode),
      .force_in (1'b0),
      .pin_i    (port_bit_fourteen_i),
      .pin_o    (port_bit_fourteen_o),
      .pin_oe   (port_bit_fourteen_oe),
      .port_do  (port_do[2]),
      .port_oe  (port_oe[2]),
      .port_di  (port_di[2]),
      .tmr_do   (timer_ch4_do[2]),
      .tmr_oe   (timer_ch4_oe[2]),
      .tmr_di   (timer_ch4_di[2]),
      .alt_do   (dma_acknowledge_zero),
      .alt_di   (),
      .force_di ()
   );

   // Bit 13: port, timer B, manual reset input; code 11 leaves the pad released.
   // The manual reset level is passed on without a change of polarity.
   pef_pin_cell #(
      .ALT_KIND      (pef_pkg::ALT_INPUT),
      .TIMER_ON_RSVD (1'b0)
   ) u_pin13 (
      .sys_clk  (sys_clk),
      .rst      (rst),
      .mode     (pin13_mode),
      .force_in (1'b0),
      .pin_i    (port_bit_thirteen_i),
      .pin_o    (port_bit_thirteen_o),
      .pin_oe   (port_bit_thirteen_oe),
      .port_do  (port_do[1]),
      .port_oe  (port_oe[1]),
      .port_di  (port_di[1]),
      .tmr_do   (timer_ch4_do[1]),
      .tmr_oe   (timer_ch4_oe[1]),
      .tmr_di   (timer_ch4_di[1]),
      .alt_do   (1'b0),
      .alt_di   (manual_reset_input),
      .force_di ()
   );

   // Bit 12: port or timer A; code 11 is served as timer A as well. The debug strap
   // passes two flip-flops first, so the test clock input follows the pad from the second
   // edge after the strap rises and the pad is released from the third; the mode field is kept.
   pef_pin_cell #(
      .ALT_KIND      (pef_pkg::ALT_NONE),
      .TIMER_ON_RSVD (1'b1)
   ) u_pin12 (
      .sys_clk  (sys_clk),
      .rst      (rst),
      .mode     (pin12_mode),
      .force_in (st_r.dbg_s2),
      .pin_i    (port_bit_twelve_i),
      .pin_o    (port_bit_twelve_o),
      .pin_oe   (port_bit_twelve_oe),
      .port_do  (port_do[0]),
      .port_oe  (port_oe[0]),
      .port_di  (port_di[0]),
      .tmr_do   (timer_ch4_do[0]),
      .tmr_oe   (timer_ch4_oe[0]),
      .tmr_di   (timer_ch4_di[0]),
      .alt_do   (1'b0),
      .alt_di   (),
      .force_di (test_clock_input)
   );

endmodule : pef_pin_select

// ==== test/pef_pin_select_monitor.sv ====
module pef_pin_select_monitor (
   // Clock and reset.
   input wire logic       sys_clk,
   input wire logic       rst,
   // Pins and units.
   input wire logic       debug_emulator_mode_pin,
   input wire logic       port_bit_thirteen_i,
   input wire logic       port_bit_twelve_i,
   input wire logic       port_bit_fourteen_o,
   input wire logic       port_bit_fourteen_oe,
   input wire logic       port_bit_thirteen_oe,
   input wire logic       port_bit_twelve_oe,
   input wire logic [2:0] timer_ch4_do,
   input wire logic [2:0] timer_ch4_oe,
   input wire logic       dma_acknowledge_zero,
   input wire logic       manual_reset_input,
   input wire logic       test_clock_input,
   // Modes.
   input wire logic [1:0] pin14_mode,
   input wire logic [1:0] pin13_mode,
   input wire logic [1:0] pin12_mode
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   a_pin14_timer: assert property (pin14_mode == 2'b01 |=>
      port_bit_fourteen_o == $past(timer_ch4_do[2])) else $error("pin14 timer out");
   a_pin14_dma: assert property (pin14_mode == 2'b10 |=> port_bit_fourteen_oe &&
      port_bit_fourteen_o == $past(dma_acknowledge_zero)) else $error("pin14 dma ack");
   a_pin13_input: assert property (pin13_mode == 2'b10 |=> !port_bit_thirteen_oe)
      else $error("pin13 driven in reset mode");
   a_pin13_reset: assert property ((pin13_mode == 2'b10 && $stable(port_bit_thirteen_i)) [*3] |->
      manual_reset_input == port_bit_thirteen_i) else $error("manual reset level");
   a_pin12_timer: assert property ((pin12_mode == 2'b01 && !debug_emulator_mode_pin) [*3] |=>
      port_bit_twelve_oe == $past(timer_ch4_oe[0])) else $error("pin12 timer enable");
   a_debug_release: assert property (debug_emulator_mode_pin [*3] |=> !port_bit_twelve_oe)
      else $error("pin12 driven in debug");
   a_debug_clock: assert property ((debug_emulator_mode_pin && $stable(port_bit_twelve_i)) [*4] |->
      test_clock_input == port_bit_twelve_i) else $error("test clock level");
   a_reset_port: assert property ($fell(rst) |-> {pin14_mode, pin13_mode, pin12_mode} == 6'h00)
      else $error("modes not cleared");
   cover property (pin14_mode == 2'b10 && port_bit_fourteen_oe);
   cover property (pin13_mode == 2'b10 && manual_reset_input);
   cover property (debug_emulator_mode_pin && test_clock_input);
endmodule : pef_pin_select_monitor

// ==== test/pef_far_side.sv ====
module pef_far_side (
   // Clock and reset.
   input  wire logic       sys_clk,
   input  wire logic       rst,
   // Timer channel 4 and DMA unit.
   output logic [2:0]      timer_ch4_do,
   output logic [2:0]      timer_ch4_oe,
   output logic            dma_acknowledge_zero
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] cnt_r;
   // Timer data moves every cycle, the enables and the DMA acknowledge every second cycle, so that a stale or wrong route shows.
   always_ff @(posedge sys_clk) cnt_r <= rst ? 4'h0 : cnt_r + 4'h1;
   assign timer_ch4_do         = cnt_r[2:0];
   assign timer_ch4_oe         = cnt_r[3:1];
   assign dma_acknowledge_zero = cnt_r[1];
endmodule : pef_far_side

// ==== test/pef_pin_select_tb.sv ====
module pef_pin_select_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        sys_clk = 0, rst = 1, hsel = 0, hwrite = 0, hready, hreadyout, hresp;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
   logic [1:0]  htrans = 0, pin14_mode, pin13_mode, pin12_mode;
   logic [2:0]  hsize = 3'h2, port_do = 0, port_oe = 0, port_di, timer_ch4_do, timer_ch4_oe, timer_ch4_di;
   logic        debug_emulator_mode_pin = 0, dma_acknowledge_zero, manual_reset_input, test_clock_input;
   logic        port_bit_fourteen_i = 0, port_bit_fourteen_o, port_bit_fourteen_oe;
   logic        port_bit_thirteen_i = 0, port_bit_thirteen_o, port_bit_thirteen_oe;
   logic        port_bit_twelve_i = 0, port_bit_twelve_o, port_bit_twelve_oe;
   int          failures = 0, tests_run = 0;
   assign hready = hreadyout;
   pef_pin_select DUT (.*);
   pef_far_side far_side (.*);
   initial forever #10 sys_clk = ~sys_clk;
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e) begin
         failures++;
         $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk
   task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= pef_pkg::HTRANS_NONSEQ;
      hwrite <= w;
      do @(posedge sys_clk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge sys_clk); while (hready !== 1'b1);
      rd = hrdata;
   endtask : xfer
   task automatic write_reg(input logic [31:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask : write_reg
   task automatic read_reg(input logic [31:0] a);
      xfer(1'b0, a, 32'h0);
   endtask : read_reg
   task automatic settle;
      repeat (4) @(posedge sys_clk);
      @(negedge sys_clk);
   endtask : settle
   task automatic end_sim;
      $display("checks %0d, mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : end_sim
   initial begin
      #100us;
      failures++;
      end_sim;
   end
   initial begin
      repeat (10) @(posedge sys_clk);
      rst <= 1'b0;
      port_do <= 3'b101;
      port_oe <= 3'b111;
      {port_bit_fourteen_i, port_bit_thirteen_i, port_bit_twelve_i} <= 3'b110;
      read_reg(32'h0);
      chk(rd, 32'h0);
      chk({hreadyout, hresp}, 2'b10);
      for (int m = 0; m < 4; m++) begin
         write_reg(32'h0, {18'h3FFFF, m[1:0], m[1:0], m[1:0], 8'hFF});
         read_reg(32'h0);
         chk(rd, {18'h0, m[1:0], m[1:0], m[1:0], 8'h00});
         settle;
         chk({pin14_mode, pin13_mode, pin12_mode}, {m[1:0], m[1:0], m[1:0]});
         chk(port_di, 3'b110);
         chk(timer_ch4_di, (m == 1) ? 3'b110 : 3'b000);
         if (m == 0) chk({port_bit_fourteen_o, port_bit_thirteen_o, port_bit_twelve_o}, 3'b101);
         if (m == 0) chk({port_bit_fourteen_oe, port_bit_thirteen_oe, port_bit_twelve_oe}, 3'b111);
         if (m == 2) chk({port_bit_fourteen_oe, port_bit_thirteen_oe, port_bit_twelve_oe}, 3'b100);
         if (m == 2) chk(manual_reset_input, 1'b1);
         if (m == 3) chk({port_bit_fourteen_oe, port_bit_thirteen_oe}, 2'b00);
      end
      write_reg(32'h4, 32'hFFFF_FFFF);
      read_reg(32'h4);
      chk(rd, 32'h0);
      read_reg(32'h0);
      chk(rd, 32'h0000_3F00);
      write_reg(32'h0, 32'h0000_0100);
      debug_emulator_mode_pin <= 1'b1;
      settle;
      chk(port_bit_twelve_oe, 1'b0);
      chk(test_clock_input, 1'b0);
      @(posedge sys_clk);
      port_bit_twelve_i <= 1'b1;
      settle;
      chk(test_clock_input, 1'b1);
      chk(timer_ch4_di[0], 1'b0);
      read_reg(32'h0);
      chk(rd, 32'h0000_0100);
      debug_emulator_mode_pin <= 1'b0;
      rst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      read_reg(32'h0);
      chk(rd, 32'h0);
      end_sim;
   end
endmodule : pef_pin_select_tb
bind pef_pin_select pef_pin_select_monitor mon (.*);
